/* File: design/roi_addr_align.sv */
// Column address correction for decimated readout.
// Assumes mode bits are stable for the frame.
module roi_addr_align
   import roi_seq_pkg::*;
(
   // Programmed addresses
   input  wire logic [XW-1:0] x_start_in,
   input  wire logic [XW-1:0] x_end_in,
   // Mode
   input  wire logic          subsample,
   input  wire logic          binning,
   // Corrected addresses
   output logic      [XW-1:0] x_start_out,
   output logic      [XW-1:0] x_end_out
);
   always_comb begin
      x_start_out = x_start_in;
      x_end_out   = x_end_in;
      if (subsample || binning) begin
         x_start_out[0] = 1'b0;
         x_end_out[0]   = binning;
      end
   end
endmodule : roi_addr_align

/* File: design/roi_readout_sequencer.sv */
// Region of interest readout sequencer with exposure and gain registers.
// Assumes a synchronous register port fed by the serial interface and
// a controller that keeps window ordering valid on every line.
import roi_seq_pkg::*;

// Behaviour
// - Decimated modes force even starts; ends even for subsampling, odd for binning.
// - Normal readout accepts any line start and line end.
// - Global shutter frame starts at first window start line, ends at last.
// - Only windows enclosing the current line are read on it.
// - Line begins at column start of lowest-numbered active window.
// - Kernel counter jumps window to window; line advances after the last.
// - Line counter may jump to the next window's start line.
// - Rolling shutter reads one selected window; selection change blanks a frame.
// - Binning averages rows too when the two-axis bit is set; not on color.
// - Subsampling reads one-skip-one on mono, two-skip-two on color.
// - Exposure counts lines in rolling, timer units in global shutter.
// - Timer multiplier sets global shutter exposure and reset granularity in logic ticks.
// - Reset length is scaled by the timer multiplier in global shutter.
// - Column amplification accepts only four codes.
// - Front-end amplification accepts only four codes.
// - Postpone bit delays new amplification by one frame.
// - Digital amplification is unsigned 5.7 fixed point, unity 0x080.
// - Binning change in global shutter blanks a frame; subsampling does not.
// - Column counter steps in kernels of 64 pixels.
module roi_readout_sequencer (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // Variant strap
   input  wire logic        COLOR_VARIANT,
   // Register port
   input  wire logic [8:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [15:0] REG_RDATA,
   output logic             REG_RVALID,
   // Readout stream
   output logic             FRAME_START,
   output logic             LINE_START,
   output logic             KERNEL_VALID,
   output logic      [6:0]  KERNEL_X,
   output logic      [12:0] LINE_Y,
   output logic      [4:0]  WINDOW_ID,
   output logic             FRAME_BLANK,
   output logic             BIN_ROWS,
   output logic             DECIMATE,
   output logic             SEQ_BUSY,
   // Amplification in use
   output logic      [4:0]  COL_AMP,
   output logic      [7:0]  AFE_AMP,
   output logic      [11:0] DIGITAL_AMP_FACTOR
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   seq_state_t        state_q;
   logic              color_q, strap_done_q;
   logic [15:0]       tick_scale_q, reset_len_q, exposure_q, analog_q, digital_q;
   logic [4:0]        ctrl_q, mode_q, roll_sel_q, roll_sel_act_q;
   logic [31:0]       roi_en_q, roi_en_act_q;
   logic [4:0]        col_pend_q;
   logic [7:0]        afe_pend_q;
   logic [11:0]       dig_pend_q;
   logic              pend_valid_q;
   logic [5:0]        copy_idx_q;
   logic [4:0]        win_idx_q;
   logic [6:0]        x_pos_q, kx_q, win_end_q;
   logic              x_done_q, first_q, cand_ok_q;
   logic [12:0]       y_q, cand_q;
   logic [19:0]       cyc_q;
   logic [16:0]       unit_q;
   logic [WIN_W-1:0]  stage_rd, act_rd, wr_mask;
   logic              win_wr;
   logic [XW-1:0]     xs_al, xe_al;
   logic [YW-1:0]     ys, ye, y_next_raw, cand_new;
   logic              rolling, subs, binn, win_en, win_on_line;
   logic [6:0]        x_step, kx_first;
   logic [12:0]       y_step;
   logic [19:0]       unit_len;
   logic [4:0]        col_in;
   logic [7:0]        afe_in;
   logic              col_ok, afe_ok, bin_change, roll_change;

   assign rolling = mode_q[CTL_ROLLING];
   assign subs    = mode_q[CTL_SUBSAMPLE];
   assign binn    = mode_q[CTL_BINNING] & ~color_q;
   assign col_in  = REG_WDATA[COL_LSB +: 5];
   assign afe_in  = REG_WDATA[AFE_LSB +: 8];
   assign col_ok  = (col_in == COL_AMP_2_3) || (col_in == COL_AMP_1) ||
                    (col_in == COL_AMP_2) || (col_in == COL_AMP_4);
   assign afe_ok  = (afe_in == AFE_AMP_100) || (afe_in == AFE_AMP_139) ||
                    (afe_in == AFE_AMP_194) || (afe_in == AFE_AMP_272);
   assign win_wr  = REG_WR && REG_ADDR[WIN_SEL_BIT];

   // ----------------------------------------
   // Strap capture after reset release
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         color_q      <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         color_q      <= COLOR_VARIANT;
         strap_done_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         tick_scale_q <= TICK_SCALE_RST;
         reset_len_q  <= RESET_LEN_RST;
         exposure_q   <= EXPOSURE_RST;
         analog_q     <= {2'h0, 1'b0, AFE_AMP_RST, COL_AMP_RST};
         digital_q    <= {4'h0, DIG_AMP_RST};
         ctrl_q       <= 5'h00;
         roll_sel_q   <= 5'h00;
         roi_en_q     <= 32'h0000_0000;
      end else if (REG_WR && !REG_ADDR[WIN_SEL_BIT]) begin
         if (REG_ADDR == REG_TICK_SCALE) begin
            tick_scale_q <= REG_WDATA;
         end else if (REG_ADDR == REG_RESET_LEN) begin
            reset_len_q <= REG_WDATA;
         end else if (REG_ADDR == REG_EXPOSURE) begin
            exposure_q <= REG_WDATA;
         end else if (REG_ADDR == REG_ANALOG_AMP) begin
            // Unsupported codes are dropped so the amplifier never sees them
            analog_q[POSTPONE_BIT] <= REG_WDATA[POSTPONE_BIT];
            if (col_ok) analog_q[COL_LSB +: 5] <= col_in;
            if (afe_ok) analog_q[AFE_LSB +: 8] <= afe_in;
         end else if (REG_ADDR == REG_DIGITAL_AMP) begin
            digital_q <= {4'h0, REG_WDATA[11:0]};
         end else if (REG_ADDR == REG_SEQ_CTRL) begin
            ctrl_q <= REG_WDATA[4:0];
         end else if (REG_ADDR == REG_ROLL_SEL) begin
            roll_sel_q <= REG_WDATA[4:0];
         end else if (REG_ADDR == REG_ROI_EN_LO) begin
            roi_en_q[15:0] <= REG_WDATA;
         end else if (REG_ADDR == REG_ROI_EN_HI) begin
            roi_en_q[31:16] <= REG_WDATA;
         end
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         REG_RDATA  <= 16'h0000;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         REG_RDATA  <= 16'h0000;
         if (REG_RD) begin
            if (REG_ADDR == REG_TICK_SCALE) REG_RDATA <= tick_scale_q;
            else if (REG_ADDR == REG_RESET_LEN) REG_RDATA <= reset_len_q;
            else if (REG_ADDR == REG_EXPOSURE) REG_RDATA <= exposure_q;
            else if (REG_ADDR == REG_ANALOG_AMP) REG_RDATA <= analog_q;
            else if (REG_ADDR == REG_DIGITAL_AMP) REG_RDATA <= digital_q;
            else if (REG_ADDR == REG_SEQ_CTRL) REG_RDATA <= {11'h000, ctrl_q};
            else if (REG_ADDR == REG_ROLL_SEL) REG_RDATA <= {11'h000, roll_sel_q};
            else if (REG_ADDR == REG_ROI_EN_LO) REG_RDATA <= roi_en_q[15:0];
            else if (REG_ADDR == REG_ROI_EN_HI) REG_RDATA <= roi_en_q[31:16];
            else if (REG_ADDR == REG_STATUS) REG_RDATA <= {12'h000, color_q, FRAME_BLANK, rolling, SEQ_BUSY};
            else if (REG_ADDR == REG_LINE) REG_RDATA <= {3'h0, y_q};
         end
      end
   end

   // ----------------------------------------
   // Window tables: staged by software, copied at frame start
   // ----------------------------------------
   always_comb begin
      wr_mask = MASK_Y_END;
      if (REG_ADDR[1:0] == FLD_X_START) wr_mask = MASK_X_START;
      else if (REG_ADDR[1:0] == FLD_X_END) wr_mask = MASK_X_END;
      else if (REG_ADDR[1:0] == FLD_Y_START) wr_mask = MASK_Y_START;
   end

   roi_table_mem #(.AW(5), .DW(WIN_W)) u_stage (
      .clk     (CLK),
      .wr_en   (win_wr),
      .wr_addr (REG_ADDR[6:2]),
      .wr_data ({REG_WDATA[XW-1:0], REG_WDATA[XW-1:0], REG_WDATA[YW-1:0], REG_WDATA[YW-1:0]}),
      .wr_mask (wr_mask),
      .rd_addr (copy_idx_q[4:0]),
      .rd_data (stage_rd)
   );

   // The active copy is what the counters read, so mid-frame writes wait
   roi_table_mem #(.AW(5), .DW(WIN_W)) u_active (
      .clk     (CLK),
      .wr_en   (state_q == S_COPY && copy_idx_q != 6'h00),
      .wr_addr (copy_idx_q[4:0] - 5'h01),
      .wr_data (stage_rd),
      .wr_mask ({WIN_W{1'b1}}),
      .rd_addr (win_idx_q),
      .rd_data (act_rd)
   );

   roi_addr_align u_align (
      .x_start_in  (act_rd[WIN_W-1 -: XW]),
      .x_end_in    (act_rd[WIN_W-XW-1 -: XW]),
      .subsample   (subs),
      .binning     (binn),
      .x_start_out (xs_al),
      .x_end_out   (xe_al)
   );

   // ----------------------------------------
   // Scan arithmetic
   // ----------------------------------------
   assign ys = act_rd[2*YW-1 -: YW];
   assign ye = act_rd[YW-1:0];
   assign x_step = (subs || binn) ? X_STEP_DECIM : X_STEP_NORMAL;

   always_comb begin
      y_step = Y_STEP_ONE;
      if (subs && color_q) y_step = y_q[0] ? Y_STEP_THREE : Y_STEP_ONE;
      else if (subs) y_step = Y_STEP_TWO;
      else if (binn && mode_q[CTL_BIN_2D]) y_step = Y_STEP_TWO;
   end

   assign y_next_raw  = first_q ? 13'h0000 : y_q + y_step;
   assign win_en      = roi_en_act_q[win_idx_q] && (!rolling || win_idx_q == roll_sel_act_q);
   assign win_on_line = win_en && !first_q && ys <= y_q && y_q <= ye && !x_done_q &&
                        xe_al >= x_pos_q;
   assign cand_new    = (ys > y_next_raw) ? ys : y_next_raw;
   assign kx_first    = (xs_al > x_pos_q) ? xs_al : x_pos_q;
   assign unit_len    = rolling ? 20'(ROW_OVERHEAD_CYCLES) : 20'(tick_scale_q * 20'(TICK_CYCLES));
   assign bin_change  = ctrl_q[CTL_BINNING] != mode_q[CTL_BINNING];
   assign roll_change = roll_sel_q != roll_sel_act_q ||
                        ctrl_q[CTL_SUBSAMPLE] != mode_q[CTL_SUBSAMPLE];

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state_q <= S_IDLE;
         copy_idx_q <= 6'h00;
         win_idx_q <= 5'h00;
         x_pos_q <= 7'h00;
         x_done_q <= 1'b0;
         kx_q <= 7'h00;
         win_end_q <= 7'h00;
         y_q <= 13'h0000;
         cand_q <= 13'h0000;
         cand_ok_q <= 1'b0;
         first_q <= 1'b0;
         cyc_q <= 20'h00000;
         unit_q <= 17'h00000;
      end else begin
         case (state_q)
            S_IDLE: begin
               copy_idx_q <= 6'h00;
               if (ctrl_q[CTL_RUN]) state_q <= S_COPY;
            end
            S_COPY: begin
               copy_idx_q <= copy_idx_q + 6'h01;
               if (copy_idx_q == 6'(NUM_WIN)) begin
                  first_q <= 1'b1;
                  state_q <= S_LINE;
               end
            end
            S_LINE: begin
               win_idx_q <= 5'h00;
               x_pos_q <= 7'h00;
               x_done_q <= 1'b0;
               cand_ok_q <= 1'b0;
               state_q <= S_RD;
            end
            S_RD: state_q <= S_EVAL;
            S_EVAL: begin
               if (win_en && ye >= y_next_raw && (!cand_ok_q || cand_new < cand_q)) begin
                  cand_q <= cand_new;
                  cand_ok_q <= 1'b1;
               end
               if (win_on_line) begin
                  kx_q <= kx_first;
                  win_end_q <= xe_al;
                  state_q <= S_KERN;
               end else if (win_idx_q == LAST_WIN) begin
                  cyc_q <= 20'h00000;
                  state_q <= S_LEND;
               end else begin
                  win_idx_q <= win_idx_q + 5'h01;
                  state_q <= S_RD;
               end
            end
            S_KERN: begin
               if ({1'b0, kx_q} + {1'b0, x_step} > {1'b0, win_end_q}) begin
                  x_pos_q <= kx_q + x_step;
                  x_done_q <= ({1'b0, kx_q} + {1'b0, x_step} > 8'h7f);
                  if (win_idx_q == LAST_WIN) begin
                     cyc_q <= 20'h00000;
                     state_q <= S_LEND;
                  end else begin
                     win_idx_q <= win_idx_q + 5'h01;
                     state_q <= S_RD;
                  end
               end else begin
                  kx_q <= kx_q + x_step;
               end
            end
            S_LEND: begin
               // Row overhead also gives software time between lines
               cyc_q <= cyc_q + 20'h00001;
               if (first_q || cyc_q == 20'(ROW_OVERHEAD_CYCLES - 1)) begin
                  first_q <= 1'b0;
                  if (cand_ok_q) begin
                     y_q <= cand_q;
                     state_q <= S_LINE;
                  end else begin
                     cyc_q <= 20'h00000;
                     unit_q <= rolling ? {1'b0, exposure_q} :
                               {1'b0, reset_len_q} + {1'b0, exposure_q};
                     state_q <= S_EXPOSE;
                  end
               end
            end
            S_EXPOSE: begin
               if (unit_q == 17'h00000) begin
                  copy_idx_q <= 6'h00;
                  state_q <= ctrl_q[CTL_RUN] ? S_COPY : S_IDLE;
               end else if (cyc_q + 20'h00001 >= unit_len) begin
                  cyc_q <= 20'h00000;
                  unit_q <= unit_q - 17'h00001;
               end else begin
                  cyc_q <= cyc_q + 20'h00001;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Frame boundary: modes, selection and gains take effect
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         mode_q <= 5'h00;
         roll_sel_act_q <= 5'h00;
         roi_en_act_q <= 32'h0000_0000;
         FRAME_BLANK <= 1'b0;
         col_pend_q <= COL_AMP_RST;
         afe_pend_q <= AFE_AMP_RST;
         dig_pend_q <= DIG_AMP_RST;
         pend_valid_q <= 1'b0;
         COL_AMP <= COL_AMP_RST;
         AFE_AMP <= AFE_AMP_RST;
         DIGITAL_AMP_FACTOR <= DIG_AMP_RST;
      end else if (state_q == S_COPY && copy_idx_q == 6'h00) begin
         mode_q <= ctrl_q;
         roll_sel_act_q <= roll_sel_q;
         roi_en_act_q <= roi_en_q;
         // Blank only frames after a change once running
         FRAME_BLANK <= (mode_q[CTL_RUN] && ctrl_q[CTL_ROLLING]) ? roll_change :
                        (mode_q[CTL_RUN] && bin_change);
         col_pend_q <= analog_q[COL_LSB +: 5];
         afe_pend_q <= analog_q[AFE_LSB +: 8];
         dig_pend_q <= digital_q[11:0];
         pend_valid_q <= analog_q[POSTPONE_BIT];
         if (pend_valid_q) begin
            COL_AMP <= col_pend_q;
            AFE_AMP <= afe_pend_q;
            DIGITAL_AMP_FACTOR <= dig_pend_q;
         end
         if (!analog_q[POSTPONE_BIT]) begin
            COL_AMP <= analog_q[COL_LSB +: 5];
            AFE_AMP <= analog_q[AFE_LSB +: 8];
            DIGITAL_AMP_FACTOR <= digital_q[11:0];
         end
      end
   end

   // ----------------------------------------
   // Stream outputs
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         FRAME_START <= 1'b0;
         LINE_START <= 1'b0;
         KERNEL_VALID <= 1'b0;
         KERNEL_X <= 7'h00;
         LINE_Y <= 13'h0000;
         WINDOW_ID <= 5'h00;
         BIN_ROWS <= 1'b0;
         DECIMATE <= 1'b0;
         SEQ_BUSY <= 1'b0;
      end else begin
         FRAME_START <= state_q == S_LEND && first_q && cand_ok_q;
         LINE_START <= state_q == S_LINE && !first_q;
         KERNEL_VALID <= state_q == S_KERN;
         KERNEL_X <= kx_q;
         LINE_Y <= y_q;
         WINDOW_ID <= win_idx_q;
         BIN_ROWS <= binn && mode_q[CTL_BIN_2D];
         DECIMATE <= subs || binn;
         SEQ_BUSY <= state_q != S_IDLE;
      end
   end
endmodule : roi_readout_sequencer

/* File: design/roi_seq_pkg.sv */
// Constants, register map and state type of the readout sequencer.
// Assumes a single 250 MHz clock domain and a parallel register port.
package roi_seq_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [8:0] REG_TICK_SCALE  = 9'h0c7;
   localparam logic [8:0] REG_RESET_LEN   = 9'h0c8;
   localparam logic [8:0] REG_EXPOSURE    = 9'h0c9;
   localparam logic [8:0] REG_ANALOG_AMP  = 9'h0cc;
   localparam logic [8:0] REG_DIGITAL_AMP = 9'h0cd;
   localparam logic [8:0] REG_SEQ_CTRL    = 9'h0e0;
   localparam logic [8:0] REG_ROLL_SEL    = 9'h0e1;
   localparam logic [8:0] REG_ROI_EN_LO   = 9'h0e2;
   localparam logic [8:0] REG_ROI_EN_HI   = 9'h0e3;
   localparam logic [8:0] REG_STATUS      = 9'h0e4;
   localparam logic [8:0] REG_LINE        = 9'h0e5;
   // Window table: bit 8 set, index in [6:2], field in [1:0]
   localparam int         WIN_SEL_BIT     = 8;
   localparam logic [1:0] FLD_X_START     = 2'h0;
   localparam logic [1:0] FLD_X_END       = 2'h1;
   localparam logic [1:0] FLD_Y_START     = 2'h2;
   localparam logic [1:0] FLD_Y_END       = 2'h3;
   // ----------------------------------------
   // Reset values and field layouts
   // ----------------------------------------
   localparam logic [15:0] TICK_SCALE_RST  = 16'h0001;
   localparam logic [15:0] RESET_LEN_RST   = 16'h0000;
   localparam logic [15:0] EXPOSURE_RST    = 16'h0000;
   localparam logic [4:0]  COL_AMP_RST     = 5'h05;
   localparam logic [7:0]  AFE_AMP_RST     = 8'h4f;
   localparam logic [11:0] DIG_AMP_RST     = 12'h080;
   localparam int COL_LSB = 0;
   localparam int AFE_LSB = 5;
   localparam int POSTPONE_BIT = 13;
   localparam logic [4:0] COL_AMP_2_3 = 5'h07;
   localparam logic [4:0] COL_AMP_1   = 5'h05;
   localparam logic [4:0] COL_AMP_2   = 5'h09;
   localparam logic [4:0] COL_AMP_4   = 5'h11;
   localparam logic [7:0] AFE_AMP_100 = 8'h4f;
   localparam logic [7:0] AFE_AMP_139 = 8'h33;
   localparam logic [7:0] AFE_AMP_194 = 8'h36;
   localparam logic [7:0] AFE_AMP_272 = 8'h66;
   localparam int CTL_RUN = 0;
   localparam int CTL_ROLLING = 1;
   localparam int CTL_SUBSAMPLE = 2;
   localparam int CTL_BINNING = 3;
   localparam int CTL_BIN_2D = 4;
   // Window entry {x_start, x_end, y_start, y_end}
   localparam int XW = 7;
   localparam int YW = 13;
   localparam int WIN_W = 2 * XW + 2 * YW;
   localparam int NUM_WIN = 32;
   localparam logic [4:0] LAST_WIN = 5'h1f;
   localparam logic [WIN_W-1:0] MASK_X_START = {{XW{1'b1}}, {(XW + 2 * YW){1'b0}}};
   localparam logic [WIN_W-1:0] MASK_X_END   = {{XW{1'b0}}, {XW{1'b1}}, {(2 * YW){1'b0}}};
   localparam logic [WIN_W-1:0] MASK_Y_START = {{(2 * XW){1'b0}}, {YW{1'b1}}, {YW{1'b0}}};
   localparam logic [WIN_W-1:0] MASK_Y_END   = {{(2 * XW + YW){1'b0}}, {YW{1'b1}}};
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TICK_PERIOD_PS = 16129;
   localparam int TICK_CYCLES = (TICK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ROW_OVERHEAD_NS = 1000;
   localparam int ROW_OVERHEAD_CYCLES = (ROW_OVERHEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [6:0] X_STEP_NORMAL = 7'h01;
   localparam logic [6:0] X_STEP_DECIM = 7'h02;
   localparam logic [12:0] Y_STEP_ONE = 13'h0001;
   localparam logic [12:0] Y_STEP_TWO = 13'h0002;
   localparam logic [12:0] Y_STEP_THREE = 13'h0003;

   typedef enum logic [2:0] {S_IDLE, S_COPY, S_LINE, S_RD, S_EVAL, S_KERN, S_LEND, S_EXPOSE} seq_state_t;
endpackage : roi_seq_pkg

/* File: design/roi_table_mem.sv */
// Small window table: one write port with a bit mask, one registered read.
// Assumes the caller holds the read address one cycle before using data.
module roi_table_mem #(
   parameter int AW = 5,
   parameter int DW = 40
) (
   // Clock
   input  wire logic          clk,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   input  wire logic [DW-1:0] wr_mask,
   // Read port
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
      end
   end

   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule : roi_table_mem

/* File: test/roi_ctrl_model.sv */
// Controller model on the far side of the register port.
// Assumes the sequencer samples strobes on the rising clock edge.
module roi_ctrl_model (
   input  wire logic        clk,
   output logic      [8:0]  addr,
   output logic      [15:0] wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [15:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {addr, wdata, wr, rd} = '0;
   // Released data is inverted so a stale word never looks valid
   task automatic wr_reg(input logic [8:0] a, input logic [15:0] v);
      @(negedge clk);
      {addr, wdata, wr} = {a, v, 1'b1};
      @(negedge clk);
      {wdata, wr} = {~v, 1'b0};
   endtask : wr_reg
   task automatic rd_reg(input logic [8:0] a, output logic [15:0] v);
      @(negedge clk);
      {addr, rd} = {a, 1'b1};
      @(negedge clk);
      v = rdata;
      rd = 1'b0;
   endtask : rd_reg
endmodule : roi_ctrl_model

/* File: test/roi_seq_properties.sv */
// Port checker for the readout sequencer.
// Assumes one clock and a synchronous active-low reset.
module roi_seq_checker (
   input wire logic        CLK, RST_B, REG_RD, REG_RVALID, FRAME_START, LINE_START,
   input wire logic        KERNEL_VALID, DECIMATE, BIN_ROWS, SEQ_BUSY,
   input wire logic [6:0]  KERNEL_X,
   input wire logic [12:0] LINE_Y,
   input wire logic [4:0]  WINDOW_ID, COL_AMP,
   input wire logic [7:0]  AFE_AMP,
   input wire logic [11:0] DIGITAL_AMP_FACTOR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence kern_pair;
      KERNEL_VALID ##1 KERNEL_VALID;
   endsequence
   a_rd_answer: assert property (REG_RVALID |-> $past(REG_RD)) else $error("read answer without request");
   a_frame_line: assert property (
      FRAME_START |-> ##[0:8] LINE_START) else $error("frame without first line");
   a_kernel_step: assert property (
      kern_pair ##0 WINDOW_ID == $past(WINDOW_ID) |-> KERNEL_X == $past(KERNEL_X) + (DECIMATE ? 7'h02 : 7'h01))
      else $error("kernel step wrong");
   a_line_steady: assert property (kern_pair |-> $stable(LINE_Y)) else $error("line moved in a line");
   a_decim_even: assert property (KERNEL_VALID && DECIMATE |-> !KERNEL_X[0]) else $error("odd kernel");
   a_bin_decim: assert property (BIN_ROWS |-> DECIMATE) else $error("row binning alone");
   a_col_legal: assert property (COL_AMP inside {5'h07, 5'h05, 5'h09, 5'h11}) else $error("column code");
   a_afe_legal: assert property (AFE_AMP inside {8'h4f, 8'h33, 8'h36, 8'h66}) else $error("front-end code");
   a_amp_frame: assert property ($changed(DIGITAL_AMP_FACTOR) |-> SEQ_BUSY) else $error("gain moved idle");
endmodule : roi_seq_checker
bind roi_readout_sequencer roi_seq_checker chk (.CLK, .RST_B, .REG_RD, .REG_RVALID, .FRAME_START, .LINE_START,
   .KERNEL_VALID, .DECIMATE, .BIN_ROWS, .SEQ_BUSY, .KERNEL_X, .LINE_Y, .WINDOW_ID, .COL_AMP, .AFE_AMP,
   .DIGITAL_AMP_FACTOR);

/* File: test/test_roi_readout_sequencer.sv */
// Self-checking bench for the readout sequencer.
// Assumes the controller model drives the register port.
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin n_fail++; $display("Error %s exp %h got %h", n, e, s); end end
module test_roi_readout_sequencer import roi_seq_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_b = 1'b0, wr, rd, rvalid, fs, kv, busy;
   logic [15:0] wdata, rdata, d, v;
   logic [8:0] addr;
   logic [31:0] seed = 32'hd4b4d250;
   logic [19:0] exp_q[$], got_q[$];
   int n_fail = 0, n_checks = 0, frames = 0, win[2][4] = '{'{2, 5, 5, 6}, '{6, 7, 6, 6}};
   logic [4:0] col, col_c[4] = '{COL_AMP_2_3, COL_AMP_1, COL_AMP_2, COL_AMP_4};
   logic [7:0] afe, afe_c[4] = '{AFE_AMP_100, AFE_AMP_139, AFE_AMP_194, AFE_AMP_272};
   logic [11:0] dig;
   logic [6:0] kx;
   logic [12:0] ly;
   always #2 clk = ~clk;
   always @(posedge clk) begin
      if (fs) frames <= frames + 1;
      if (kv && frames == 1) got_q.push_back({ly, kx});
   end
   roi_ctrl_model ctl (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   roi_readout_sequencer dut (.CLK(clk), .RST_B(rst_b), .COLOR_VARIANT(1'b0), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .FRAME_START(fs), .LINE_START(),
      .KERNEL_VALID(kv), .KERNEL_X(kx), .LINE_Y(ly), .WINDOW_ID(), .FRAME_BLANK(), .BIN_ROWS(), .DECIMATE(),
      .SEQ_BUSY(busy), .COL_AMP(col), .AFE_AMP(afe), .DIGITAL_AMP_FACTOR(dig));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      test_done;
   end
   initial begin
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      `CHK("col_amp", 5'h05, col)
      `CHK("dig_amp", 12'h080, dig)
      for (int i = 0; i < 4; i++) begin
         ctl.rd_reg(i == 3 ? 9'h0ff : REG_TICK_SCALE + 9'(i), d);
         `CHK("reg_reset", i == 0 ? 16'h0001 : 16'h0000, d)
      end
      seed = lfsr(seed);
      v = {2'b00, seed[13:2], 2'b01};
      ctl.wr_reg(REG_TICK_SCALE, v);
      ctl.rd_reg(REG_TICK_SCALE, d);
      `CHK("tick_scale", v, d)
      `CHK("rvalid", 1'b1, rvalid)
      for (int i = 0; i < 5; i++) begin
         v = i < 4 ? {3'b000, afe_c[i], col_c[i]} : {3'b000, 8'h4f, 5'h1f};
         ctl.wr_reg(REG_ANALOG_AMP, v);
         ctl.rd_reg(REG_ANALOG_AMP, d);
         `CHK("analog_amp", i < 4 ? v : 16'h09f1, d)
      end
      seed = lfsr(seed);
      ctl.wr_reg(REG_DIGITAL_AMP, {4'h0, seed[11:0]});
      `CHK("dig_amp", 12'h080, dig)
      // Starts and x ends rise with window index; both y ends are 6
      for (int i = 0; i < 8; i++) ctl.wr_reg(9'h100 + 9'(i), 16'(win[i / 4][i % 4]));
      ctl.wr_reg(REG_ROI_EN_LO, 16'h0003);
      for (int m = 0; m < 2; m++) begin
         frames = 0;
         got_q.delete();
         exp_q.delete();
         ctl.wr_reg(REG_SEQ_CTRL, m ? 16'h0005 : 16'h0001);
         while (frames < 2) @(negedge clk);
         ctl.wr_reg(REG_SEQ_CTRL, 16'h0000);
         while (busy) @(negedge clk);
         ctl.rd_reg(REG_STATUS, d);
         `CHK("status", 16'h0000, d)
         for (int y = 5; y < 8; y += m + 1)
            for (int w = 0; w < 2; w++)
               for (int x = win[w][0] & ~m; x <= (win[w][1] & ~m); x += m + 1)
                  if (y >= win[w][2] && y <= win[w][3]) exp_q.push_back({13'(y), 7'(x)});
         `CHK("kernel_count", exp_q.size(), got_q.size())
         foreach (exp_q[i]) `CHK("kernel", exp_q[i], got_q[i])
      end
      `CHK("dig_amp", seed[11:0], dig)
      `CHK("col_amp", COL_AMP_4, col)
      `CHK("afe_amp", AFE_AMP_100, afe)
      test_done;
   end
endmodule : test_roi_readout_sequencer
